// ===== include/battery_supply_defines.vh
// Purpose: constants for the battery supply PWM control block
// Assumes: 40 MHz mclk_in, 16.384 MHz converter time base
// Notes: definitions only
`ifndef BATTERY_SUPPLY_DEFINES_VH
`define BATTERY_SUPPLY_DEFINES_VH

// Register offsets
`define ADDR_IND_DATA_LO 8'h1C
`define ADDR_IND_DATA_HI 8'h1D
`define ADDR_IND_WRITE 8'h1E
`define ADDR_IND_READ 8'h1F
`define ADDR_POWER_DOWN 8'h0E
`define ADDR_LINEFEED_BAT 8'h42
`define ADDR_BAT_AUTO 8'h43
`define ADDR_HIGH_BAT 8'h4A
`define ADDR_LOW_BAT 8'h4B
`define ADDR_PWM_PERIOD 8'h5C
`define ADDR_SW_DELAY 8'h5D
`define ADDR_PULSE_WIDTH 8'h5E
`define ADDR_ENHANCE 8'h6C
`define IND_ADDR_HEADROOM 8'h29

// Field positions
`define BIT_CONV_OFF 4
`define BIT_FEED_SELECT 1
`define BIT_HEADROOM_RANGE 6
`define BIT_AUTO_SELECT 3
`define BIT_CALIBRATE 7
`define BIT_POLARITY 5
`define BIT_MULTI_THRESH 5
`define BIT_AUDIO_FILTER 1
`define BIT_SW_DEBOUNCE 3

// Reset values
`define RST_POWER_DOWN 8'h10
`define RST_LINEFEED_BAT 8'h00
`define RST_BAT_AUTO 8'h00
`define RST_HIGH_BAT 6'h20
`define RST_LOW_BAT 6'h10
`define RST_PWM_PERIOD 8'hFF
`define RST_MIN_OFF 5'h00
`define RST_ENHANCE 8'h00

// Timing and loop limits
`define MIN_OFF_EXTRA 8'h04
`define TICK_INC 17'h04000
`define TICK_MOD 17'h09C40
`define CAL_TICKS 8'hFF
`define DEBOUNCE_MS 60
`define DEBOUNCE_TICKS (`DEBOUNCE_MS * 16384)
`define HEADROOM_MAX_NARROW 4'h6
`define HEADROOM_MAX_WIDE 4'h9
`define MULTI_ERR_LIMIT 7'h04
`define MULTI_STEP 8'h04

`endif

// ===== src/battery_supply_pwm_control.v
// Purpose: PWM buck-boost control and battery select for a line interface
// Assumes: 40 MHz mclk_in; 16.384 MHz time base made by a phase accumulator
// Notes: battery_sense_in is a magnitude code in 1.5 V steps
// What this block does
// - Assist output has polarity opposite to the drive output unless POLARITY_VARIANT is set, then it matches drive.
// - Converter runs only while power-off bit 4 of register 14 is zero.
// - Sensed battery compared to target; result steers switching.
// - Monitor overload forces switches off for the rest of the period.
// - Period set by 8-bit register 92, 61.035 ns per count.
// - Switches asserted each period for width reported in register 94.
// - Each cycle holds minimum off time of field value plus 4 counts.
// - Tracking follows falling loop demand; otherwise floor at low level.
// - High and low levels are 6-bit fields, 1.5 V steps.
// - During ringing regulate to high level, then return to active.
// - Headroom offset added, 4-bit indirect field plus range bit.
// - Register 108 bit 5 selects multi-threshold error control.
// - Register 108 bit 1 enables audio band loop filter.
// - Automatic select switches battery; low on ring trip or closure.
// - Manual select follows battery feed select bit 1 of register 66.
// - Register 108 bit 3 delays high-to-low switch by 60 ms.
// - Headroom field reached only through indirect registers 28-31.
// - Register 93 bit 5 reads the fixed output polarity variant.
`include "battery_supply_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module battery_supply_pwm_control #(
	parameter [19:0] DEBOUNCE_CYCLES = `DEBOUNCE_TICKS,
	parameter [0:0] POLARITY_VARIANT = 1'b0
) (
	input wire mclk_in,
	input wire rst_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire [6:0] battery_sense_in,
	input wire supply_monitor_high_in,
	input wire supply_monitor_low_in,
	input wire [6:0] loop_demand_in,
	input wire ringing_in,
	input wire off_hook_in,
	output reg switch_drive_out,
	output reg switch_assist_out,
	output reg battery_low_out
);
	reg [7:0] power_down_r;
	reg [7:0] linefeed_bat_r;
	reg [7:0] bat_auto_r;
	reg [5:0] high_bat_r;
	reg [5:0] low_bat_r;
	reg [7:0] pwm_period_r;
	reg [4:0] min_off_r;
	reg [7:0] enhance_r;
	reg [7:0] ind_lo_r;
	reg [7:0] ind_hi_r;
	reg [3:0] headroom_r;
	reg [16:0] tick_acc_r;
	reg tick_r;
	reg [7:0] period_cnt_r;
	reg [7:0] pulse_r;
	reg overload_r;
	reg cal_busy_r;
	reg [7:0] cal_cnt_r;
	reg ref_high_r;
	reg ref_low_r;
	reg last_below_r;
	reg [19:0] deb_cnt_r;
	wire [8:0] sync_w;
	wire [6:0] sense_w;
	wire mon_high_w;
	wire mon_low_w;
	wire conv_off_w;
	wire period_end_w;
	wire overload_now_w;
	wire [3:0] headroom_lim_w;
	reg [6:0] base_w;
	reg [6:0] target_w;
	reg below_w;
	reg [7:0] max_pulse_w;
	reg [7:0] pulse_nxt;
	reg switch_on_w;
	reg want_low_w;
	reg [16:0] tick_sum_w;

	// Multi-bit sense code is assumed to change slowly versus the clock
	input_sync #(
		.WIDTH(9)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in({battery_sense_in, supply_monitor_high_in,
			supply_monitor_low_in}),
		.sync_out(sync_w)
	);
	assign sense_w = sync_w[8:2];
	assign mon_high_w = sync_w[1];
	assign mon_low_w = sync_w[0];

	assign conv_off_w = power_down_r[`BIT_CONV_OFF];

	// Register writes; indirect headroom only via indirect registers
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			power_down_r <= `RST_POWER_DOWN;
			linefeed_bat_r <= `RST_LINEFEED_BAT;
			bat_auto_r <= `RST_BAT_AUTO;
			high_bat_r <= `RST_HIGH_BAT;
			low_bat_r <= `RST_LOW_BAT;
			pwm_period_r <= `RST_PWM_PERIOD;
			min_off_r <= `RST_MIN_OFF;
			enhance_r <= `RST_ENHANCE;
			ind_lo_r <= 8'h00;
			ind_hi_r <= 8'h00;
			headroom_r <= 4'h0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `ADDR_POWER_DOWN) begin
				power_down_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_LINEFEED_BAT) begin
				linefeed_bat_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_BAT_AUTO) begin
				bat_auto_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_HIGH_BAT) begin
				high_bat_r <= reg_wdata_in[5:0];
			end else if (reg_addr_in == `ADDR_LOW_BAT) begin
				low_bat_r <= reg_wdata_in[5:0];
			end else if (reg_addr_in == `ADDR_PWM_PERIOD) begin
				pwm_period_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_SW_DELAY) begin
				min_off_r <= reg_wdata_in[4:0];
			end else if (reg_addr_in == `ADDR_ENHANCE) begin
				enhance_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_IND_DATA_LO) begin
				ind_lo_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_IND_DATA_HI) begin
				ind_hi_r <= reg_wdata_in;
			end else if (reg_addr_in == `ADDR_IND_WRITE) begin
				if (reg_wdata_in == `IND_ADDR_HEADROOM) begin
					headroom_r <= ind_lo_r[3:0];
				end
			end else if (reg_addr_in == `ADDR_IND_READ) begin
				ind_hi_r <= 8'h00;
				if (reg_wdata_in == `IND_ADDR_HEADROOM) begin
					ind_lo_r <= {4'h0, headroom_r};
				end else begin
					ind_lo_r <= 8'h00;
				end
			end
		end
	end

	// Register reads, data held in a flop until the next read
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == `ADDR_POWER_DOWN) begin
				reg_rdata_out <= power_down_r;
			end else if (reg_addr_in == `ADDR_LINEFEED_BAT) begin
				reg_rdata_out <= linefeed_bat_r;
			end else if (reg_addr_in == `ADDR_BAT_AUTO) begin
				reg_rdata_out <= bat_auto_r;
			end else if (reg_addr_in == `ADDR_HIGH_BAT) begin
				reg_rdata_out <= {2'b00, high_bat_r};
			end else if (reg_addr_in == `ADDR_LOW_BAT) begin
				reg_rdata_out <= {2'b00, low_bat_r};
			end else if (reg_addr_in == `ADDR_PWM_PERIOD) begin
				reg_rdata_out <= pwm_period_r;
			end else if (reg_addr_in == `ADDR_SW_DELAY) begin
				reg_rdata_out <= {cal_busy_r, 1'b0, POLARITY_VARIANT,
					min_off_r};
			end else if (reg_addr_in == `ADDR_PULSE_WIDTH) begin
				reg_rdata_out <= pulse_r;
			end else if (reg_addr_in == `ADDR_ENHANCE) begin
				reg_rdata_out <= enhance_r;
			end else if (reg_addr_in == `ADDR_IND_DATA_LO) begin
				reg_rdata_out <= ind_lo_r;
			end else if (reg_addr_in == `ADDR_IND_DATA_HI) begin
				reg_rdata_out <= ind_hi_r;
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	always @* begin
		tick_sum_w = tick_acc_r + `TICK_INC;
	end
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_acc_r <= 17'h00000;
			tick_r <= 1'b0;
		end else if (tick_sum_w >= `TICK_MOD) begin
			tick_acc_r <= tick_sum_w - `TICK_MOD;
			tick_r <= 1'b1;
		end else begin
			tick_acc_r <= tick_sum_w;
			tick_r <= 1'b0;
		end
	end

	assign period_end_w = tick_r && (period_cnt_r + 8'h01 >= pwm_period_r);
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			period_cnt_r <= 8'h00;
		end else if (conv_off_w) begin
			period_cnt_r <= 8'h00;
		end else if (period_end_w) begin
			period_cnt_r <= 8'h00;
		end else if (tick_r) begin
			period_cnt_r <= period_cnt_r + 8'h01;
		end
	end

	// calibration run captures idle monitor levels
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cal_busy_r <= 1'b0;
			cal_cnt_r <= 8'h00;
			ref_high_r <= 1'b0;
			ref_low_r <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == `ADDR_SW_DELAY &&
			reg_wdata_in[`BIT_CALIBRATE]) begin
			cal_busy_r <= 1'b1;
			cal_cnt_r <= 8'h00;
		end else if (cal_busy_r && tick_r) begin
			if (cal_cnt_r == `CAL_TICKS) begin
				cal_busy_r <= 1'b0;
				ref_high_r <= mon_high_w;
				ref_low_r <= mon_low_w;
			end else begin
				cal_cnt_r <= cal_cnt_r + 8'h01;
			end
		end
	end

	// overload latch, cleared at period end
	assign overload_now_w = !cal_busy_r &&
		(mon_high_w != ref_high_r || mon_low_w != ref_low_r);
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			overload_r <= 1'b0;
		end else if (overload_now_w) begin
			overload_r <= 1'b1;
		end else if (period_end_w || conv_off_w) begin
			overload_r <= 1'b0;
		end
	end

	assign headroom_lim_w =
		linefeed_bat_r[`BIT_HEADROOM_RANGE] ? `HEADROOM_MAX_WIDE :
		`HEADROOM_MAX_NARROW;

	always @* begin
		if (ringing_in) begin
			base_w = {1'b0, high_bat_r};
		// floor at low level unless tracking
		end else if (!linefeed_bat_r[0] &&
			loop_demand_in < {1'b0, low_bat_r}) begin
			base_w = {1'b0, low_bat_r};
		end else begin
			base_w = loop_demand_in;
		end
		if (headroom_r > headroom_lim_w) begin
			target_w = base_w + {3'b000, headroom_lim_w};
		end else begin
			target_w = base_w + {3'b000, headroom_r};
		end
		below_w = sense_w < target_w;
		// room left for minimum off time
		if (pwm_period_r > {3'b000, min_off_r} + `MIN_OFF_EXTRA) begin
			max_pulse_w = pwm_period_r - {3'b000, min_off_r} -
				`MIN_OFF_EXTRA;
		end else begin
			max_pulse_w = 8'h00;
		end
		pulse_nxt = pulse_r;
		// with audio filter set, act only on two agreeing samples
		if (!enhance_r[`BIT_AUDIO_FILTER] || below_w == last_below_r) begin
			if (below_w) begin
				if (enhance_r[`BIT_MULTI_THRESH] &&
					target_w - sense_w > `MULTI_ERR_LIMIT) begin
					pulse_nxt = pulse_r + `MULTI_STEP;
				end else begin
					pulse_nxt = pulse_r + 8'h01;
				end
				if (pulse_nxt < pulse_r || pulse_nxt > max_pulse_w) begin
					pulse_nxt = max_pulse_w;
				end
			end else if (pulse_r != 8'h00) begin
				if (enhance_r[`BIT_MULTI_THRESH] &&
					sense_w - target_w > `MULTI_ERR_LIMIT &&
					pulse_r > `MULTI_STEP) begin
					pulse_nxt = pulse_r - `MULTI_STEP;
				end else begin
					pulse_nxt = pulse_r - 8'h01;
				end
			end
		end
		if (pulse_nxt > max_pulse_w) begin
			pulse_nxt = max_pulse_w;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_r <= 8'h00;
			last_below_r <= 1'b0;
		end else if (conv_off_w) begin
			pulse_r <= 8'h00;
		end else if (period_end_w) begin
			pulse_r <= pulse_nxt;
			last_below_r <= below_w;
		end
	end

	always @* begin
		switch_on_w = !conv_off_w && !overload_r && !overload_now_w &&
			!cal_busy_r && period_cnt_r < pulse_r;
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			switch_drive_out <= 1'b0;
			switch_assist_out <= !POLARITY_VARIANT;
		end else begin
			switch_drive_out <= switch_on_w;
			switch_assist_out <= POLARITY_VARIANT ? switch_on_w :
				!switch_on_w;
		end
	end

	always @* begin
		if (bat_auto_r[`BIT_AUTO_SELECT]) begin
			want_low_w = off_hook_in && !ringing_in;
		end else begin
			want_low_w = linefeed_bat_r[`BIT_FEED_SELECT];
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			battery_low_out <= 1'b0;
			deb_cnt_r <= 20'h00000;
		end else if (!want_low_w) begin
			battery_low_out <= 1'b0;
			deb_cnt_r <= 20'h00000;
		end else if (battery_low_out) begin
			deb_cnt_r <= 20'h00000;
		end else if (!enhance_r[`BIT_SW_DEBOUNCE]) begin
			battery_low_out <= 1'b1;
		end else if (tick_r) begin
			if (deb_cnt_r + 20'h00001 >= DEBOUNCE_CYCLES) begin
				battery_low_out <= 1'b1;
			end else begin
				deb_cnt_r <= deb_cnt_r + 20'h00001;
			end
		end
	end
endmodule // battery_supply_pwm_control
`default_nettype wire

// ===== src/input_sync.v
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single clock mclk_in
// Notes: one generate block per bit
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter WIDTH = 1
) (
	input wire mclk_in,
	input wire rst_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_r;
			reg stable_r;
			always @(posedge mclk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_r <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r <= async_in[i];
					stable_r <= meta_r;
				end
			end
			assign sync_out[i] = stable_r;
		end
	endgenerate
endmodule // input_sync
`default_nettype wire

// ===== testbench/battery_supply_checker_assertions.sv
// Purpose: port-level checker for battery_supply_pwm_control
// Assumes: shadows of a few control bits rebuilt from register writes
// Notes: bound from the testbench top file
`include "battery_supply_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module battery_supply_checker #(
	parameter [19:0] DEBOUNCE_CYCLES = 20'h00014,
	parameter [0:0] POLARITY_VARIANT = 1'b0
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [6:0] battery_sense_in,
	input wire logic supply_monitor_high_in,
	input wire logic supply_monitor_low_in,
	input wire logic [6:0] loop_demand_in,
	input wire logic ringing_in,
	input wire logic off_hook_in,
	input wire logic switch_drive_out,
	input wire logic switch_assist_out,
	input wire logic battery_low_out
);
	logic off_r;
	logic feed_r;
	logic auto_r;
	logic db_r;
	wire logic want_low = auto_r ? (off_hook_in & !ringing_in) : feed_r;

	// Shadows only track writes; the block's own copies are not visible
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			off_r <= 1'b1;
			feed_r <= 1'b0;
			auto_r <= 1'b0;
			db_r <= 1'b0;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`ADDR_POWER_DOWN: off_r <= reg_wdata_in[4];
				`ADDR_LINEFEED_BAT: feed_r <= reg_wdata_in[1];
				`ADDR_BAT_AUTO: auto_r <= reg_wdata_in[3];
				`ADDR_ENHANCE: db_r <= reg_wdata_in[3];
				default: off_r <= off_r;
			endcase
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	AST_ASSIST_POL: assert property (
		switch_assist_out == (switch_drive_out ^ !POLARITY_VARIANT))
		else $error("assist polarity wrong");
	AST_OFF_QUIET: assert property (
		off_r [*3] |-> !switch_drive_out)
		else $error("drive while converter off");
	AST_MIN_OFF: assert property (
		$fell(switch_drive_out) |-> !switch_drive_out [*7])
		else $error("off interval too short");
	AST_MANUAL_SEL: assert property (
		(!auto_r && !db_r && $stable(feed_r)) [*3]
		|-> battery_low_out == feed_r)
		else $error("manual battery select not followed");
	AST_AUTO_SEL: assert property (
		(auto_r && !db_r && $stable(want_low)) [*3]
		|-> battery_low_out == want_low)
		else $error("automatic battery select wrong");
	AST_RING_HIGH: assert property (
		(auto_r && ringing_in) [*2] |-> !battery_low_out)
		else $error("low battery during ringing");
	AST_DEBOUNCE: assert property (
		db_r && $rose(want_low) |-> !battery_low_out [*8])
		else $error("high to low switch not delayed");
	AST_POL_READ: assert property (
		$past(reg_rd_in) && $past(reg_addr_in) == `ADDR_SW_DELAY
		|-> reg_rdata_out[5] == POLARITY_VARIANT)
		else $error("polarity variant bit wrong");
endmodule // battery_supply_checker
`default_nettype wire

// ===== testbench/power_stage_model.sv
// Purpose: behavioural converter power stage driven by a bench-set level
// Assumes: sense level slews one code every four clocks
// Notes: monitors show overload only when the bench asks
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [6:0] level_in,
	input wire logic overload_in,
	output logic [6:0] sense_out,
	output logic mon_high_out,
	output logic mon_low_out
);
	logic [1:0] slow_r;

	// Slow slew so the loop sees a lagging output, as a real cap would
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			slow_r <= 2'h0;
			sense_out <= 7'h00;
		end else begin
			slow_r <= slow_r + 2'h1;
			if (slow_r == 2'h3 && sense_out < level_in)
				sense_out <= sense_out + 7'h01;
			else if (slow_r == 2'h3 && sense_out > level_in)
				sense_out <= sense_out - 7'h01;
		end
	end
	assign mon_high_out = overload_in;
	assign mon_low_out = 1'b0;
endmodule // power_stage_model
`default_nettype wire

// ===== testbench/test_battery_supply_pwm_control.sv
// Purpose: register-level test of battery_supply_pwm_control
// Assumes: 40 MHz clock, debounce shortened to 20 ticks
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_battery_supply_pwm_control;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdat = 8'h00;
	logic [7:0] v;
	logic ring = 1'b0;
	logic hook = 1'b0;
	logic [6:0] lvl = 7'h00;
	logic [6:0] dem = 7'h10;
	logic ovl = 1'b0;
	wire logic [7:0] rdat;
	wire logic [6:0] sense;
	wire logic mon_hi;
	wire logic mon_lo;
	wire logic drv;
	wire logic bat_low;
	int fails = 0;
	int cmp_count = 0;
	int hi;
	int per;
	int i;
	logic [7:0] ra [7] = '{8'h0E, 8'h5C, 8'h4A, 8'h4B, 8'h5D, 8'h43, 8'h01};
	logic [7:0] rv [7] = '{8'h10, 8'hFF, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00};

	always #12.5 mclk_in = ~mclk_in;

	battery_supply_pwm_control #(.DEBOUNCE_CYCLES(20'h00014)) u_dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .battery_sense_in(sense),
		.supply_monitor_high_in(mon_hi), .supply_monitor_low_in(mon_lo),
		.loop_demand_in(dem), .ringing_in(ring), .off_hook_in(hook),
		.switch_drive_out(drv), .switch_assist_out(),
		.battery_low_out(bat_low));
	power_stage_model u_ps (.mclk_in(mclk_in), .rst_in(rst_in),
		.level_in(lvl), .overload_in(ovl), .sense_out(sense),
		.mon_high_out(mon_hi), .mon_low_out(mon_lo));

	task automatic close_out;
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic wreg(input logic [7:0] a, d);
		@(negedge mclk_in);
		addr = a;
		wdat = d;
		wr = 1'b1;
		@(negedge mclk_in);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(negedge mclk_in);
		addr = a;
		rd = 1'b1;
		@(negedge mclk_in);
		rd = 1'b0;
		v = rdat;
	endtask
	// A stuck drive ends the run instead of hanging it
	task automatic wait_drv(input logic lvl);
		i = 0;
		while (drv !== lvl && i < 3000) begin
			@(negedge mclk_in);
			i++;
		end
		if (drv !== lvl) begin
			fails++;
			close_out();
		end
	endtask
	task automatic measure;
		wait_drv(1'b0);
		wait_drv(1'b1);
		hi = 0;
		per = 0;
		while (drv === 1'b1 && per < 999) begin
			@(negedge mclk_in);
			hi++;
			per++;
		end
		while (drv === 1'b0 && per < 999) begin
			@(negedge mclk_in);
			per++;
		end
		if (per >= 999) begin
			fails++;
			close_out();
		end
	endtask
	task automatic count_hi;
		hi = 0;
		repeat (200) begin
			@(negedge mclk_in);
			if (drv !== 1'b0)
				hi++;
		end
	endtask

	initial begin
		wt(5);
		rst_in = 1'b0;
		foreach (ra[k]) begin
			rreg(ra[k]);
			chk("reset value", v, rv[k]);
		end
		wreg(8'h5E, 8'hAA);
		rreg(8'h5E);
		chk("width read only", v, 8'h00);
		wreg(8'h1C, 8'h37);
		wreg(8'h1D, 8'h00);
		wreg(8'h1E, 8'h29);
		wreg(8'h1C, 8'h00);
		wreg(8'h1F, 8'h29);
		rreg(8'h1C);
		chk("headroom", v, 8'h07);
		wreg(8'h4A, 8'hFF);
		rreg(8'h4A);
		chk("high level", v, 8'h3F);
		wreg(8'h42, 8'h02);
		wt(4);
		chk("manual low", bat_low, 1'b1);
		wreg(8'h42, 8'h00);
		wt(4);
		chk("manual high", bat_low, 1'b0);
		wreg(8'h43, 8'h08);
		hook = 1'b1;
		wt(4);
		chk("auto low", bat_low, 1'b1);
		ring = 1'b1;
		wt(3);
		chk("ringing high", bat_low, 1'b0);
		ring = 1'b0;
		hook = 1'b0;
		wreg(8'h6C, 8'h08);
		hook = 1'b1;
		wt(10);
		chk("debounce hold", bat_low, 1'b0);
		wt(80);
		chk("debounce end", bat_low, 1'b1);
		hook = 1'b0;
		wreg(8'h6C, 8'h00);
		wreg(8'h43, 8'h00);
		// Short period keeps the ramp to full width cheap to simulate
		wreg(8'h5C, 8'h20);
		wreg(8'h0E, 8'h00);
		wreg(8'h5D, 8'h83);
		i = 0;
		do begin
			wt(20);
			rreg(8'h5D);
			i++;
		end while (v[7] !== 1'b0 && i < 100);
		chk("calibration", v, 8'h03);
		if (v[7] !== 1'b0)
			close_out();
		for (int n = 0; n < 2; n++) begin
			wt(2500);
			rreg(8'h5E);
			chk("max width", v, 8'h19);
			if (n == 0) begin
				measure();
				chk("high time", 8'(hi >= 59 && hi <= 63), 8'h01);
				chk("period", 8'(per >= 76 && per <= 80), 8'h01);
				wait_drv(1'b1);
				wt(10);
				ovl = 1'b1;
				wt(5);
				chk("overload cut", drv, 1'b0);
				ovl = 1'b0;
				wt(10);
				chk("overload rest", drv, 1'b0);
				wreg(8'h0E, 8'h10);
				count_hi();
				chk("power off", 8'(hi), 8'h00);
				wreg(8'h0E, 8'h00);
			end
		end
		lvl = 7'h7F;
		wreg(8'h6C, 8'h22);
		wt(500);
		rreg(8'h5E);
		chk("fast step", 8'(v <= 8'h0D), 8'h01);
		wt(1000);
		rreg(8'h5E);
		chk("width above", v, 8'h00);
		count_hi();
		chk("quiet above", 8'(hi), 8'h00);
		// Sense parked between the floored and the tracking targets
		lvl = 7'h12;
		dem = 7'h08;
		wreg(8'h42, 8'h00);
		wt(3000);
		rreg(8'h5E);
		chk("floor at low", v, 8'h19);
		wreg(8'h42, 8'h01);
		wt(3000);
		rreg(8'h5E);
		chk("tracking", v, 8'h00);
		// Sense equal to the narrow target, one code below the wide one
		lvl = 7'h16;
		dem = 7'h10;
		wreg(8'h42, 8'h41);
		wt(3000);
		rreg(8'h5E);
		chk("wide headroom", v, 8'h19);
		close_out();
	end
endmodule // test_battery_supply_pwm_control

bind battery_supply_pwm_control battery_supply_checker #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .POLARITY_VARIANT(POLARITY_VARIANT)
) u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.battery_sense_in(battery_sense_in),
	.supply_monitor_high_in(supply_monitor_high_in),
	.supply_monitor_low_in(supply_monitor_low_in),
	.loop_demand_in(loop_demand_in), .ringing_in(ringing_in),
	.off_hook_in(off_hook_in), .switch_drive_out(switch_drive_out),
	.switch_assist_out(switch_assist_out),
	.battery_low_out(battery_low_out));
`default_nettype wire
